// ---- dram_cfg_pkg.sv ----
// Package with register map, field layout, reset values, timing counts and state codes.
package dram_cfg_pkg;
  localparam int unsigned ADDR_W        = 28;
  localparam int unsigned PADDR_W       = 12;
  localparam int unsigned PHASE_W       = 5;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned BUS_STATE_NS  = 400;
  localparam int unsigned STATE_CYCLES  = (BUS_STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CAS_HI_50_PCT = 50;
  localparam int unsigned CAS_HI_35_PCT = 35;
  localparam logic [PHASE_W-1:0] CAS_HI_50 = PHASE_W'(STATE_CYCLES * CAS_HI_50_PCT / 100);
  localparam logic [PHASE_W-1:0] CAS_HI_35 = PHASE_W'(STATE_CYCLES * CAS_HI_35_PCT / 100);

  localparam logic [PADDR_W-1:0] OFF_WAIT_CTRL = 12'h000;
  localparam logic [PADDR_W-1:0] OFF_DRAM_CTRL = 12'h004;
  localparam logic [PADDR_W-1:0] OFF_BUS_CTRL  = 12'h008;
  localparam logic [PADDR_W-1:0] OFF_STATUS    = 12'h00c;

  localparam logic [15:0] WAIT_CTRL_RST  = 16'hf800;
  localparam logic [15:0] WAIT_CTRL_MASK = 16'hf800;
  localparam logic [15:0] DRAM_CTRL_RST  = 16'h0000;
  localparam logic [15:0] DRAM_CTRL_MASK = 16'hff00;

  localparam int unsigned WAIT_PIN_PULLUP_BIT   = 15;
  localparam int unsigned AREA02_LW_POS         = 13;
  localparam int unsigned AREA6_LW_POS          = 11;
  localparam int unsigned STROBE_SCHEME_BIT     = 15;
  localparam int unsigned RAS_HOLD_BIT          = 14;
  localparam int unsigned PRECHARGE_LEN_BIT     = 13;
  localparam int unsigned PAGE_BURST_BIT        = 12;
  localparam int unsigned CAS_DUTY_BIT          = 11;
  localparam int unsigned ADDR_MUX_BIT          = 10;
  localparam int unsigned ROW_SHIFT_POS         = 8;
  localparam int unsigned DRAM_SPACE_ENABLE_BIT = 0;

  localparam logic [2:0] AREA_ZERO = 3'h0;
  localparam logic [2:0] AREA_DRAM = 3'h1;
  localparam logic [2:0] AREA_TWO  = 3'h2;
  localparam logic [2:0] AREA_SIX  = 3'h6;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ROW  = 3'b001,
    ST_COL  = 3'b010,
    ST_PRE  = 3'b011,
    ST_EXT  = 3'b100
  } state_t;
endpackage

// ---- state_time_if.sv ----
// Interface between the access engine and its bus-state timer.
`timescale 1ns/1ps
interface state_time_if;
  logic                             run;
  logic                             tick;
  logic [dram_cfg_pkg::PHASE_W-1:0] phase;
  modport timer (input run, output tick, output phase);
  modport user  (output run, input tick, input phase);
endinterface

// ---- state_timer.sv ----
// Bus-state timer that divides the clock into states of fixed length.
`timescale 1ns/1ps
module state_timer #(
  parameter int unsigned CYCLES = dram_cfg_pkg::STATE_CYCLES
) (
  // Clock and reset.
  input wire logic   i_ref_clk,
  input wire logic   i_rst,
  // Engine side.
  state_time_if.timer tm
);
  import dram_cfg_pkg::*;

  typedef struct packed {
    logic [PHASE_W-1:0] phase;
  } timer_t;

  timer_t q;
  timer_t d;

  assign tm.tick  = tm.run && (q.phase == PHASE_W'(CYCLES - 1));
  assign tm.phase = q.phase;

  always_comb begin
    d = q;
    if (!tm.run || tm.tick) begin
      d.phase = '0;
    end else begin
      d.phase = q.phase + 5'h01;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ---- dram_config_and_long_wait.sv ----
// Wait and DRAM area configuration registers with the external access engine they steer.
`timescale 1ns/1ps
module dram_config_and_long_wait (
  // Clock, resets and standby.
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_manual_rst,
  input  wire logic                          i_standby,
  // APB register port.
  input  wire logic                          i_psel,
  input  wire logic                          i_penable,
  input  wire logic                          i_pwrite,
  input  wire logic [dram_cfg_pkg::PADDR_W-1:0] i_paddr,
  input  wire logic [31:0]                   i_pwdata,
  output logic [31:0]                        o_prdata,
  output logic                               o_pready,
  output logic                               o_pslverr,
  // External access requests.
  input  wire logic                          i_req_valid,
  input  wire logic [dram_cfg_pkg::ADDR_W-1:0] i_req_addr,
  input  wire logic [2:0]                    i_req_area,
  input  wire logic                          i_req_write,
  input  wire logic                          i_req_upper,
  input  wire logic                          i_req_lower,
  input  wire logic                          i_req_bus16,
  input  wire logic                          i_req_wait_sample,
  output logic                               o_req_ready,
  output logic                               o_req_done,
  // Memory pins.
  input  wire logic                          i_wait_n,
  output logic                               o_wait_pin_pullup_en,
  output logic                               o_ras_n,
  output logic                               o_upper_byte_cas_n,
  output logic                               o_lower_byte_cas_n,
  output logic                               o_upper_byte_write_strobe_n,
  output logic                               o_lower_byte_write_strobe_n,
  output logic [dram_cfg_pkg::ADDR_W-1:0]    o_addr
);
  import dram_cfg_pkg::*;

  typedef struct packed {
    logic [15:0]       wait_ctrl;
    logic [15:0]       dram_ctrl;
    logic              dram_space_enable;
    logic [31:0]       prdata;
    logic              perr;
    logic [1:0]        wait_sync;
    state_t            state;
    logic [2:0]        cnt;
    logic              pend;
    logic [ADDR_W-1:0] req_addr;
    logic              req_we;
    logic              req_up;
    logic              req_lo;
    logic              req_b16;
    logic              req_smp;
    logic [ADDR_W-1:0] last_addr;
    logic              row_valid;
    logic              ras_n;
    logic              ucas_n;
    logic              lcas_n;
    logic              uwe_n;
    logic              lwe_n;
    logic [ADDR_W-1:0] addr;
    logic              done;
  } eng_t;

  localparam eng_t ENG_RST = '{wait_ctrl: WAIT_CTRL_RST, dram_ctrl: DRAM_CTRL_RST, state: ST_IDLE, wait_sync: 2'b11,
                               ras_n: 1'b1, ucas_n: 1'b1, lcas_n: 1'b1, uwe_n: 1'b1, lwe_n: 1'b1,
                               default: '0};

  function automatic logic [2:0] long_wait_states(input logic [1:0] code);
    long_wait_states = {1'b0, code} + 3'h1;
  endfunction

  function automatic logic [3:0] row_shift(input logic [1:0] code);
    unique case (code)
      2'b01:   row_shift = 4'h9;
      2'b10:   row_shift = 4'ha;
      default: row_shift = 4'h8;
    endcase
  endfunction

  eng_t q;
  eng_t d;

  state_time_if tm ();

  state_timer state_timer_inst (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .tm        (tm)
  );

  logic              dram_en;
  logic              ras_hold;
  logic              burst;
  logic              mux_en;
  logic              scheme;
  logic [1:0]        lw02;
  logic [1:0]        lw6;
  logic [3:0]        shift;
  logic [2:0]        pre_cnt;
  logic [PHASE_W-1:0] cas_hi;
  logic              hold_ok;
  logic              accept;
  logic              is_dram;
  logic              row_hit;
  logic              setup;
  logic              wr_en;
  logic              cas_act;
  logic              col;
  logic              cas_high_win;

  assign dram_en  = q.dram_space_enable;
  assign ras_hold = q.dram_ctrl[RAS_HOLD_BIT];
  assign burst    = q.dram_ctrl[PAGE_BURST_BIT];
  assign mux_en   = q.dram_ctrl[ADDR_MUX_BIT];
  assign scheme   = q.dram_ctrl[STROBE_SCHEME_BIT];
  assign lw02     = q.wait_ctrl[AREA02_LW_POS +: 2];
  assign lw6      = q.wait_ctrl[AREA6_LW_POS +: 2];
  assign shift    = row_shift(q.dram_ctrl[ROW_SHIFT_POS +: 2]);
  assign pre_cnt  = {2'b00, q.dram_ctrl[PRECHARGE_LEN_BIT]};
  assign cas_hi   = q.dram_ctrl[CAS_DUTY_BIT] ? CAS_HI_35 : CAS_HI_50;
  assign hold_ok  = q.ras_n || (ras_hold && dram_en);
  assign o_req_ready = (q.state == ST_IDLE) && !i_standby && !i_manual_rst && !q.pend && hold_ok;
  assign accept   = i_req_valid && o_req_ready;
  assign is_dram  = (i_req_area == AREA_DRAM) && dram_en;
  assign row_hit  = ((i_req_addr ^ q.last_addr) >> shift) == '0;
  assign setup    = i_psel && !i_penable;
  assign wr_en    = i_psel && i_penable && i_pwrite;
  assign col      = q.state == ST_COL;
  assign cas_act  = col && (tm.phase >= cas_hi);
  assign cas_high_win = col && (tm.phase < cas_hi);
  assign tm.run   = q.state != ST_IDLE;

  assign o_prdata  = q.prdata;
  assign o_pready  = i_psel && i_penable;
  assign o_pslverr = i_psel && i_penable && q.perr;
  assign o_req_done = q.done;
  assign o_wait_pin_pullup_en = q.wait_ctrl[WAIT_PIN_PULLUP_BIT];
  assign o_ras_n = q.ras_n;
  assign o_upper_byte_cas_n = q.ucas_n;
  assign o_lower_byte_cas_n = q.lcas_n;
  assign o_upper_byte_write_strobe_n = q.uwe_n;
  assign o_lower_byte_write_strobe_n = q.lwe_n;
  assign o_addr = q.addr;

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.wait_sync = {q.wait_sync[0], i_wait_n};
    if (setup) begin
      d.perr = 1'b0;
      d.prdata = '0;
      unique case (i_paddr)
        OFF_WAIT_CTRL: d.prdata = {16'h0000, q.wait_ctrl};
        OFF_DRAM_CTRL: d.prdata = {16'h0000, q.dram_ctrl};
        OFF_BUS_CTRL:  d.prdata = {31'h0, q.dram_space_enable};
        OFF_STATUS:    d.prdata = {26'h0, q.row_valid, ~q.ras_n, q.pend, q.state};
        default:       d.perr = 1'b1;
      endcase
    end
    if (wr_en) begin
      unique case (i_paddr)
        OFF_WAIT_CTRL: d.wait_ctrl = i_pwdata[15:0] & WAIT_CTRL_MASK;
        OFF_DRAM_CTRL: d.dram_ctrl = i_pwdata[15:0] & DRAM_CTRL_MASK;
        OFF_BUS_CTRL:  d.dram_space_enable = i_pwdata[DRAM_SPACE_ENABLE_BIT];
        default:       d.perr = q.perr;
      endcase
    end
    unique case (q.state)
      ST_IDLE: begin
        if (!hold_ok) begin
          d.state = ST_PRE;
          d.ras_n = 1'b1;
          d.row_valid = 1'b0;
          d.cnt = pre_cnt;
        end else if (accept) begin
          d.req_addr = i_req_addr;
          d.req_we = i_req_write;
          d.req_up = i_req_upper;
          d.req_lo = i_req_lower;
          d.req_b16 = i_req_bus16;
          d.req_smp = i_req_wait_sample;
          d.cnt = 3'h0;
          d.addr = i_req_addr;
          if (!is_dram) begin
            d.state = ST_EXT;
            if (i_req_area == AREA_ZERO || i_req_area == AREA_TWO) begin
              d.cnt = long_wait_states(lw02);
            end else if (i_req_area == AREA_SIX) begin
              d.cnt = long_wait_states(lw6);
            end
          end else if (burst && q.row_valid && !q.ras_n && row_hit) begin
            d.state = ST_COL;
          end else if (!q.ras_n) begin
            d.state = ST_PRE;
            d.ras_n = 1'b1;
            d.row_valid = 1'b0;
            d.pend = 1'b1;
            d.cnt = pre_cnt;
          end else begin
            d.state = ST_ROW;
            d.ras_n = 1'b0;
            d.addr = mux_en ? (i_req_addr >> shift) : i_req_addr;
          end
        end
      end
      ST_ROW: begin
        if (tm.tick) begin
          d.state = ST_COL;
          d.addr = q.req_addr;
        end
      end
      ST_COL: begin
        if (tm.tick) begin
          d.done = 1'b1;
          d.last_addr = q.req_addr;
          if (ras_hold && dram_en) begin
            d.state = ST_IDLE;
            d.row_valid = 1'b1;
          end else begin
            d.state = ST_PRE;
            d.ras_n = 1'b1;
            d.row_valid = 1'b0;
            d.cnt = pre_cnt;
          end
        end
      end
      ST_PRE: begin
        if (tm.tick) begin
          if (q.cnt != 3'h0) begin
            d.cnt = q.cnt - 3'h1;
          end else if (q.pend) begin
            d.state = ST_ROW;
            d.pend = 1'b0;
            d.ras_n = 1'b0;
            d.addr = mux_en ? (q.req_addr >> shift) : q.req_addr;
          end else begin
            d.state = ST_IDLE;
          end
        end
      end
      ST_EXT: begin
        if (tm.tick) begin
          if (q.cnt != 3'h0) begin
            d.cnt = q.cnt - 3'h1;
          end else if (!(q.req_smp && !q.wait_sync[1])) begin
            d.state = ST_IDLE;
            d.done = 1'b1;
          end
        end
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase
    d.ucas_n = 1'b1;
    d.uwe_n = 1'b1;
    d.lcas_n = !(cas_act && (!q.req_b16 || scheme || q.req_lo));
    d.lwe_n = !(col && q.req_we && (!q.req_b16 || !scheme || q.req_lo));
    if (q.req_b16) begin
      d.ucas_n = !(cas_act && !scheme && q.req_up);
      d.uwe_n = !(col && q.req_we && scheme && q.req_up);
    end
    if (i_manual_rst) begin
      d.state = ST_IDLE;
      d.cnt = 3'h0;
      d.pend = 1'b0;
      d.row_valid = 1'b0;
      d.ras_n = 1'b1;
      d.ucas_n = 1'b1;
      d.lcas_n = 1'b1;
      d.uwe_n = 1'b1;
      d.lwe_n = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= ENG_RST;
    end else begin
      q <= d;
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  logic acc_ext02;
  logic acc_hit;
  logic acc_miss;
  assign acc_ext02 = accept && !is_dram && (i_req_area == AREA_ZERO || i_req_area == AREA_TWO) && !wr_en;
  assign acc_hit = accept && is_dram && burst && q.row_valid && !q.ras_n && row_hit && !i_manual_rst;
  assign acc_miss = accept && is_dram && !burst && q.ras_n && !i_manual_rst;

  sequence s_col_only;
    (q.state == ST_COL && o_ras_n == 1'b0) [*2];
  endsequence

  sequence s_row_first;
    (q.state == ST_ROW && !o_ras_n) ##1 (q.state == ST_ROW);
  endsequence

  AST_WAIT_RESERVED: assert property (q.wait_ctrl[10:0] == 11'h000)
    else $error("Reserved wait control bits are set.");
  AST_DRAM_RESERVED: assert property (q.dram_ctrl[7:0] == 8'h00)
    else $error("Reserved DRAM control bits are set.");
  AST_PULLUP: assert property (o_wait_pin_pullup_en == q.wait_ctrl[WAIT_PIN_PULLUP_BIT])
    else $error("Pull-up output differs from its control bit.");
  AST_KEEP_ON_MANUAL: assert property (i_manual_rst && !wr_en |=> $stable(q.wait_ctrl) && $stable(q.dram_ctrl))
    else $error("Configuration changed on manual reset.");
  AST_NO_DRAM_WHEN_OFF: assert property (!dram_en && q.ras_n && q.state == ST_IDLE |=> q.state != ST_ROW)
    else $error("DRAM cycle started with DRAM space disabled.");
  AST_LONG_WAIT: assert property (acc_ext02 |=> q.cnt == long_wait_states($past(lw02)))
    else $error("Area 0/2 long wait count wrong.");
  AST_BURST_HIT: assert property (acc_hit |=> s_col_only)
    else $error("Burst row hit did not go to column only.");
  AST_FULL_ACCESS: assert property (acc_miss |=> s_row_first)
    else $error("Full access did not start with row phase.");
  AST_CAS_DUTY: assert property ($past(cas_high_win) |-> o_lower_byte_cas_n && o_upper_byte_cas_n)
    else $error("CAS low inside its high phase.");
  AST_EIGHT_BIT: assert property (!q.req_b16 |=> o_upper_byte_cas_n && o_upper_byte_write_strobe_n)
    else $error("Upper strobe active in eight-bit space.");
  AST_ROW_INVALID: assert property (o_ras_n && q.state != ST_COL |-> !q.row_valid)
    else $error("Row marked valid with RAS high.");
endmodule

// ---- mem_partner.sv ----
// Far-side memory model that can hold the wait line low for a set number of cycles.
`timescale 1ns/1ps
module mem_partner (
  // Clock.
  input  wire logic       i_ref_clk,
  // Test control.
  input  wire logic [7:0] i_stall,
  input  wire logic       i_start,
  // Wait pin.
  output logic            o_wait_n
);
  int left = 0;

  always @(posedge i_ref_clk) begin
    if (i_start)
      left <= int'(i_stall);
    else if (left > 0)
      left <= left - 1;
  end

  // A released line is always driven high, to the pull-up level.
  assign o_wait_n = (left > 0) ? 1'b0 : 1'b1;
endmodule

// ---- dram_config_and_long_wait_tb.sv ----
// Self-checking bench for the configuration registers and the access engine.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, s); end end
module dram_config_and_long_wait_tb;
  import dram_cfg_pkg::*;
  typedef struct {int lo; int hi; logic [27:0] row; int rowat; logic [3:0] strb; logic cd; bit ck; logic ras;
    int pre;} acc_t;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_manual_rst = 1'b0, i_standby = 1'b0;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, o_pready, o_pslverr;
  logic [PADDR_W-1:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, o_prdata;
  logic i_req_valid = 1'b0, i_req_write = 1'b0, i_req_upper = 1'b0, i_req_lower = 1'b0, i_req_bus16 = 1'b0;
  logic i_req_wait_sample = 1'b0, i_wait_n, p_start = 1'b0, o_req_ready, o_req_done, o_wait_pin_pullup_en;
  logic o_ras_n, o_upper_byte_cas_n, o_lower_byte_cas_n, o_upper_byte_write_strobe_n, o_lower_byte_write_strobe_n;
  logic [7:0] p_stall = '0;
  logic [ADDR_W-1:0] i_req_addr = '0, o_addr;
  logic [2:0] i_req_area = '0;
  logic cw_cfg = 1'b0, cd_cfg = 1'b0;
  logic [32:0] rd_q[$];
  acc_t acc_q[$];
  acc_t cur;
  int err_count = 0, n_compared = 0, seed = 96, cyc = 0, cnt = 0, pc = -1;
  bit busy = 0;
  wire [3:0] strobes = {o_upper_byte_cas_n, o_lower_byte_cas_n, o_upper_byte_write_strobe_n,
                        o_lower_byte_write_strobe_n};

  always #10 i_ref_clk = ~i_ref_clk;

  dram_config_and_long_wait dram_config_and_long_wait_inst (.i_ref_clk, .i_rst, .i_manual_rst, .i_standby,
    .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_req_valid,
    .i_req_addr, .i_req_area, .i_req_write, .i_req_upper, .i_req_lower, .i_req_bus16, .i_req_wait_sample,
    .o_req_ready, .o_req_done, .i_wait_n, .o_wait_pin_pullup_en, .o_ras_n, .o_upper_byte_cas_n,
    .o_lower_byte_cas_n, .o_upper_byte_write_strobe_n, .o_lower_byte_write_strobe_n, .o_addr);

  mem_partner mem_partner_inst (.i_ref_clk, .i_stall(p_stall), .i_start(p_start), .o_wait_n(i_wait_n));

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [3:0] exp_strb(input logic cw, input logic b16, input logic w, input logic l);
    if (!b16)
      return {1'b1, 1'b0, 1'b1, ~w};
    if (!cw)
      return {1'b0, ~l, 1'b1, ~w};
    return {1'b1, 1'b0, ~w, ~(w & l)};
  endfunction

  function automatic acc_t mk(input int lo, input int pre, input logic ras);
    acc_t e;
    e = '{lo:lo, hi:lo + 1, row:'0, rowat:0, strb:'0, cd:1'b1, ck:0, ras:ras, pre:pre};
    return e;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge i_ref_clk);
    if (!w)
      rd_q.push_back(e);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do @(posedge i_ref_clk); while (o_pready !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic acc(input logic [2:0] ar, input logic [27:0] ad, input logic b16, input logic w, input logic l,
                     input acc_t e);
    @(posedge i_ref_clk);
    acc_q.push_back(e);
    i_req_valid <= 1'b1;
    i_req_area <= ar;
    i_req_addr <= ad;
    i_req_bus16 <= b16;
    i_req_write <= w;
    i_req_upper <= 1'b1;
    i_req_lower <= l;
    do @(posedge i_ref_clk); while (o_req_ready !== 1'b1);
    i_req_valid <= 1'b0;
    while (acc_q.size() != 0 || busy || pc >= 0) @(posedge i_ref_clk);
  endtask

  task automatic dram(input logic [27:0] ad, input int lo, input int pre, input logic ras, input int rowat,
                      input logic [27:0] row, input logic b16);
    acc_t e;
    logic [1:0] r;
    r = 2'($random(seed));
    e = mk(lo, pre, ras);
    e.strb = exp_strb(cw_cfg, b16, r[0], r[1]);
    e.cd = cd_cfg ? e.strb[2] : 1'b1;
    e.ck = 1;
    e.row = row;
    e.rowat = rowat;
    acc(AREA_DRAM, ad, b16, r[0], r[1], e);
  endtask

  task automatic mrst();
    @(posedge i_ref_clk);
    i_manual_rst <= 1'b1;
    @(posedge i_ref_clk);
    i_manual_rst <= 1'b0;
  endtask

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end

  always @(posedge i_ref_clk) begin
    logic [32:0] ev;
    if (i_psel && i_penable && o_pready && !i_pwrite) begin
      ev = rd_q.pop_front();
      `CHK("register read", ev, {o_pslverr, o_prdata})
    end
    if (pc >= 0) begin
      pc++;
      if (o_req_ready === 1'b1) begin
        `CHK("precharge", 1'b1, pc >= cur.pre && pc <= cur.pre + 1)
        pc = -1;
      end
    end
    if (busy) begin
      cnt++;
      if (cnt == cur.rowat) `CHK("row address", cur.row, o_addr)
      if (cnt == cur.lo - 11 && cur.ck) `CHK("cas duty", cur.cd, o_lower_byte_cas_n)
      if (cnt == cur.lo - 1 && cur.ck) `CHK("strobes", cur.strb, strobes)
      if (o_req_done === 1'b1) begin
        `CHK("access length", 1'b1, cnt >= cur.lo && cnt <= cur.hi)
        `CHK("ras level", cur.ras, o_ras_n)
        busy = 0;
        pc = (cur.pre >= 0) ? 0 : -1;
      end
    end else if (i_req_valid && o_req_ready === 1'b1) begin
      busy = 1;
      cnt = 0;
      cur = acc_q.pop_front();
    end
  end

  initial begin
    logic [15:0] v;
    logic [27:0] a;
    acc_t e;
    int sh;
    bit hit;
    repeat (8) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    `CHK("pullup", 1'b1, o_wait_pin_pullup_en)
    apb(0, OFF_WAIT_CTRL, 0, {17'h0, WAIT_CTRL_RST});
    apb(0, OFF_DRAM_CTRL, 0, {17'h0, DRAM_CTRL_RST});
    v = 16'($random(seed));
    apb(1, OFF_WAIT_CTRL, {16'h0, v}, '0);
    apb(0, OFF_WAIT_CTRL, 0, {17'h0, v & WAIT_CTRL_MASK});
    `CHK("pullup", v[15], o_wait_pin_pullup_en)
    v = 16'($random(seed));
    apb(1, OFF_DRAM_CTRL, {16'h0, v}, '0);
    apb(0, OFF_DRAM_CTRL, 0, {17'h0, v & DRAM_CTRL_MASK});
    apb(1, 12'h010, 32'hffff_ffff, '0);
    apb(0, 12'h010, 0, {1'b1, 32'h0});
    apb(1, OFF_WAIT_CTRL, 32'h2800, '0);
    apb(1, OFF_DRAM_CTRL, 32'h5500, '0);
    @(posedge i_ref_clk);
    i_manual_rst <= 1'b1;
    i_standby <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_manual_rst <= 1'b0;
    i_standby <= 1'b0;
    apb(0, OFF_WAIT_CTRL, 0, 33'h2800);
    apb(0, OFF_DRAM_CTRL, 0, 33'h5500);
    for (int k = 0; k < 4; k++) begin
      a = 28'($random(seed));
      apb(1, OFF_WAIT_CTRL, 32'h8000 | (k << 13) | ((3 - k) << 11), '0);
      acc(AREA_ZERO, a, 1'b1, 1'b1, 1'b1, mk((2 + k) * 20 + 1, -1, 1'b1));
      acc(AREA_TWO, a, 1'b1, 1'b0, 1'b1, mk((2 + k) * 20 + 1, -1, 1'b1));
      acc(AREA_SIX, a, 1'b1, 1'b1, 1'b1, mk((5 - k) * 20 + 1, -1, 1'b1));
    end
    apb(1, OFF_WAIT_CTRL, 32'h0, '0);
    p_stall <= 8'd100;
    p_start <= 1'b1;
    i_req_wait_sample <= 1'b1;
    @(posedge i_ref_clk);
    p_start <= 1'b0;
    e = mk(61, -1, 1'b1);
    e.hi = 181;
    acc(AREA_ZERO, a, 1'b1, 1'b0, 1'b1, e);
    i_req_wait_sample <= 1'b0;
    apb(1, OFF_DRAM_CTRL, 32'h5000, '0);
    acc(AREA_DRAM, a, 1'b1, 1'b1, 1'b1, mk(21, -1, 1'b1));
    apb(1, OFF_BUS_CTRL, 32'h1, '0);
    apb(1, OFF_DRAM_CTRL, 32'h0, '0);
    a = 28'($random(seed));
    dram(a, 41, 20, 1'b1, 2, a, 1'b1);
    dram(a, 41, 20, 1'b1, 2, a, 1'b1);
    apb(1, OFF_DRAM_CTRL, 32'had00, '0);
    cw_cfg = 1'b1;
    cd_cfg = 1'b1;
    dram(a, 41, 40, 1'b1, 2, a >> 9, 1'b1);
    dram(a, 41, 40, 1'b1, 2, a >> 9, 1'b0);
    cw_cfg = 1'b0;
    cd_cfg = 1'b0;
    for (int k = 0; k < 4; k++) begin
      sh = (k == 1) ? 9 : (k == 2) ? 10 : 8;
      hit = (k == 1 || k == 2);
      apb(1, OFF_DRAM_CTRL, 32'h5400 | (k << 8), '0);
      mrst();
      a = 28'($random(seed));
      dram(a, 41, -1, 1'b0, 2, a >> sh, 1'b1);
      dram(a ^ 28'h100, hit ? 21 : 61, -1, 1'b0, hit ? 0 : 22, (a ^ 28'h100) >> sh, 1'b1);
      dram(a ^ 28'h400, 61, -1, 1'b0, 22, (a ^ 28'h400) >> sh, 1'b1);
    end
    mrst();
    dram(a ^ 28'h400, 41, -1, 1'b0, 2, (a ^ 28'h400) >> 8, 1'b1);
    apb(0, OFF_STATUS, 0, 33'h30);
    apb(0, OFF_BUS_CTRL, 0, 33'h1);
    results();
  end
endmodule
